/* File: shared/ards_pkg.sv */
package ards_pkg;

    // widths
    localparam int DATA_W  = 16;
    localparam int WIDE_W  = 20;
    localparam int RF_N    = 32;
    localparam int RF_AW   = 5;
    localparam int ALU_OPW = 5;
    localparam int SPC_W   = 4;
    localparam int BSRC_W  = 2;
    localparam int SH_W    = 2;

    // register file: locations 0..15 are 16-bit data, 16..31 are 20-bit address
    localparam logic [RF_AW-1:0] RF_DATA_R1   = 5'h01;
    localparam logic [RF_AW-1:0] RF_ADDR_BASE = 5'h10;
    localparam logic [RF_AW-1:0] RF_KEY_LOC   = 5'h0e;

    // processor key register fields (bit 0 is msb in documented numbering)
    localparam int KEY_RING_LSB  = 13;
    localparam int KEY_ID_LSB    = 6;
    localparam int KEY_LEVEL_LSB = 0;
    localparam logic [15:0] KEY_FIXED_MASK = 16'h9c00;
    localparam logic [5:0]  LEVEL_HIGHEST  = 6'h00;
    localparam logic [5:0]  LEVEL_LOWEST   = 6'h3f;

    // special-control write micro-ops
    typedef enum logic [SPC_W-1:0] {
        SPC_NONE          = 4'h0,
        SPC_LOW_FIELD     = 4'h1,
        SPC_UPPER_NIBBLE  = 4'h2,
        SPC_PORTA_TO_BUS  = 4'h3,
        SPC_ALU_DIRECT    = 4'h4,
        SPC_BYTE_SWAP     = 4'h5,
        SPC_SHIFT_LEFT    = 4'h6,
        SPC_SHIFT_RIGHT   = 4'h7,
        SPC_SHIFT_RIGHT_F = 4'h8
    } ards_spc_e;

    // alu control field codes
    typedef enum logic [ALU_OPW-1:0] {
        ALU_AND    = 5'h00,
        ALU_OR     = 5'h01,
        ALU_XOR    = 5'h02,
        ALU_NOTB   = 5'h03,
        ALU_NOTA   = 5'h04,
        ALU_ADD    = 5'h05,
        ALU_SUB    = 5'h06,
        ALU_ADD_P1 = 5'h07,
        ALU_SUB_M1 = 5'h08,
        ALU_A_P1   = 5'h09,
        ALU_A_M1   = 5'h0a,
        ALU_PASS_A = 5'h0b,
        ALU_PASS_B = 5'h0c,
        ALU_ZERO   = 5'h0d,
        ALU_ONES   = 5'h0e,
        ALU_ZSUB   = 5'h0f
    } ards_alu_e;

    typedef enum logic [BSRC_W-1:0] {
        BSRC_G      = 2'h0,
        BSRC_Q16    = 2'h1,
        BSRC_Q8     = 2'h2,
        BSRC_Q7     = 2'h3
    } ards_bsrc_e;

    typedef enum logic [SH_W-1:0] {
        SHIFT_OP_MIDDLE_NONE   = 2'h0,
        SHIFT_OP_MIDDLE_FIRST  = 2'h1,
        SHIFT_OP_MIDDLE_MIDDLE = 2'h2,
        SHIFT_OP_MIDDLE_FINAL  = 2'h3
    } ards_shift_op_middle_e;

    // software shift type codes from functional register bits 8-11
    localparam logic [3:0] SH_SINGLE_OPEN_LEFT    = 4'h0;
    localparam logic [3:0] SH_SINGLE_CLOSED_LEFT  = 4'h1;
    localparam logic [3:0] SH_SINGLE_ARITH_LEFT   = 4'h2;
    localparam logic [3:0] SH_DOUBLE_CLOSED_LEFT  = 4'h3;
    localparam logic [3:0] SH_SINGLE_OPEN_RIGHT   = 4'h4;
    localparam logic [3:0] SH_SINGLE_CLOSED_RIGHT = 4'h5;
    localparam logic [3:0] SH_SINGLE_ARITH_RIGHT  = 4'h6;
    localparam logic [3:0] SH_DOUBLE_CLOSED_RIGHT = 4'h7;
    localparam logic [3:0] SH_DOUBLE_OPEN_LEFT    = 4'h8;
    localparam logic [3:0] SH_DOUBLE_OPEN_LEFT16  = 4'h9;
    localparam logic [3:0] SH_DOUBLE_ARITH_LEFT   = 4'ha;
    localparam logic [3:0] SH_DOUBLE_ARITH_LEFT16 = 4'hb;
    localparam logic [3:0] SH_DOUBLE_OPEN_RIGHT   = 4'hc;
    localparam logic [3:0] SH_DOUBLE_OPEN_RIGHT16 = 4'hd;
    localparam logic [3:0] SH_DOUBLE_ARITH_RIGHT  = 4'he;
    localparam logic [3:0] SH_DOUBLE_ARITH_RIGHT16 = 4'hf;

    // microword fields used by this datapath
    typedef struct packed {
        logic                   regfile_load_bit;
        logic [RF_AW-1:0]       rf_addr;
        logic                   rf_addr_from_f;
        ards_spc_e              spc;
        ards_alu_e              alu_op;
        logic                   a_zero;
        ards_bsrc_e             b_src;
        logic                   b_zero;
        logic                   bus_other_src;
        logic                   load_q;
        logic                   load_g;
        logic                   load_f;
        ards_shift_op_middle_e             shift_op_middle;
    } ards_uword_s;

    typedef struct packed {
        logic                   c16;
        logic                   v16;
        logic                   c20;
        logic                   v20;
    } ards_flags_s;

    typedef struct packed {
        logic [1:0]             ring;
        logic                   privileged;
        logic [3:0]             proc_id;
        logic [5:0]             level;
        logic                   level_highest;
        logic                   level_lowest;
    } ards_key_s;

    typedef struct packed {
        logic [3:0]             shift_type;
        logic                   is_double;
        logic                   is_right;
        logic                   is_arith;
        logic                   is_closed;
        logic                   over15;
        logic [4:0]             count;
        logic                   count_from_r1;
        logic [2:0]             odd_reg;
        logic [2:0]             even_reg;
    } ards_shdec_s;

endpackage

/* File: verilog/ards_datapath.sv */
//Contract
// - load bit clear leaves file unchanged
// - upper nibble op writes extension from bus
// - byte swap write, extension gets bus 12-15; the code loads bus 0-3 into it
// - shift ops write shifted alu, fill op
// - no special op writes all bits
// - direct alu ops write unshifted alu
// - seven data registers, location zero instruction
// - seven base registers plus panel base
// - key register field layout
// - ring 00,01 user; 10,11 privileged
// - level zero highest, 63 lowest
// - carry and overflow at 16 and 20
// - 16-bit a-port operand sign-extended
// - a-port zero operand select
// - b-port g, zero, q fields sign-extended
// - alu drives bus by default
// - direct or one-bit shifted file path
// - flags captured for next cycle
// - logic, arithmetic, increments, constant outputs
// - shift codes 0-7 decode
// - shift codes 8-e decode
// - 16-bit paths combine into 32-bit
// - code f double arith right
// - count field chosen by bit 8
// - zero count takes register one
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
module ards_datapath (
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_n_i,
    input  wire ards_pkg::ards_uword_s      uword_i,
    input  wire logic [ards_pkg::WIDE_W-1:0] bus_in_i,
    input  wire logic                       shift_fill_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    input  wire logic [1:0]                 reg_addr_i,
    input  wire logic [15:0]                reg_wdata_i,
    output logic [15:0]                     reg_rdata_o,
    output logic [ards_pkg::WIDE_W-1:0]     internal_bus_o,
    output logic [ards_pkg::WIDE_W-1:0]     alu_out_o,
    output ards_pkg::ards_flags_s           flags_o,
    output ards_pkg::ards_key_s             key_o,
    output ards_pkg::ards_shdec_s           shdec_o
);
    import ards_pkg::*;

    localparam logic [1:0] REG_FUNC  = 2'h0;
    localparam logic [1:0] REG_KEY   = 2'h1;
    localparam logic [1:0] REG_FLAGS = 2'h2;
    localparam logic [1:0] REG_Q     = 2'h3;

    typedef struct packed {
        logic [WIDE_W-1:0]      g;
        logic [DATA_W-1:0]      q;
        logic [DATA_W-1:0]      func;
        ards_flags_s            flags;
        logic [15:0]            rdata;
        logic [WIDE_W-1:0]      bus;
    } ards_state_s;

    ////////////////////////////////////////////////////////////////////////
    // reset release
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file: low 16 locations 16-bit, high 16 locations 20-bit
    logic [DATA_W-1:0]   rf_lo_q [RF_N];
    logic [3:0]          rf_ext_q [RF_N];
    ards_state_s         st_q;
    ards_state_s         st_d;

    logic [RF_AW-1:0]    rf_sel;
    logic                sel_wide;
    logic [WIDE_W-1:0]   port_a_raw;
    logic [WIDE_W-1:0]   op_a;
    logic [WIDE_W-1:0]   op_b;
    logic [WIDE_W:0]     sum;
    logic [DATA_W:0]     sum16;
    logic [WIDE_W-1:0]   alu;
    logic [WIDE_W-1:0]   shifted;
    logic [WIDE_W-1:0]   wr_val;
    logic                wr_lo;
    logic                wr_ext;
    logic                swap;
    logic                c16;
    logic                c20;
    logic                cin;
    logic [WIDE_W-1:0]   bsub;

    // register address from microword or functional register bits 1-3
    assign rf_sel   = uword_i.rf_addr_from_f ? {2'b00, st_q.func[14:12]} : uword_i.rf_addr;
    assign sel_wide = rf_sel[4];
    assign port_a_raw = sel_wide ? {rf_ext_q[rf_sel], rf_lo_q[rf_sel]}
                                 : {{4{rf_lo_q[rf_sel][15]}}, rf_lo_q[rf_sel]};
    assign op_a = (uword_i.a_zero || uword_i.alu_op == ALU_ZSUB) ? '0 : port_a_raw;

    always_comb begin
        case (uword_i.b_src)
            BSRC_G:   op_b = st_q.g;
            BSRC_Q16: op_b = {{4{st_q.q[15]}}, st_q.q};
            BSRC_Q8:  op_b = {{12{st_q.q[7]}}, st_q.q[7:0]};
            default:  op_b = {{13{st_q.q[6]}}, st_q.q[6:0]};
        endcase
        if (uword_i.b_zero) begin
            op_b = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alu
    always_comb begin
        bsub = op_b;
        cin  = 1'b0;
        case (uword_i.alu_op)
            ALU_ADD:    begin bsub = op_b;  cin = 1'b0; end
            ALU_SUB:    begin bsub = ~op_b; cin = 1'b1; end
            ALU_ZSUB:   begin bsub = ~op_b; cin = 1'b1; end
            ALU_ADD_P1: begin bsub = op_b;  cin = 1'b1; end
            ALU_SUB_M1: begin bsub = ~op_b; cin = 1'b0; end
            ALU_A_P1:   begin bsub = '0;    cin = 1'b1; end
            ALU_A_M1:   begin bsub = '1;    cin = 1'b0; end
            default:    begin bsub = op_b;  cin = 1'b0; end
        endcase
        sum = {1'b0, op_a} + {1'b0, bsub} + {{WIDE_W{1'b0}}, cin};
        sum16 = {1'b0, op_a[15:0]} + {1'b0, bsub[15:0]} + {16'h0000, cin};
        c16 = sum16[DATA_W];
        c20 = sum[WIDE_W];
        case (uword_i.alu_op)
            ALU_AND:    alu = op_a & op_b;
            ALU_OR:     alu = op_a | op_b;
            ALU_XOR:    alu = op_a ^ op_b;
            ALU_NOTB:   alu = ~op_b;
            ALU_NOTA:   alu = ~op_a;
            ALU_PASS_A: alu = op_a;
            ALU_PASS_B: alu = op_b;
            ALU_ZERO:   alu = '0;
            ALU_ONES:   alu = '1;
            default:    alu = sum[WIDE_W-1:0];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // register file write selection
    always_comb begin
        case (uword_i.spc)
            SPC_SHIFT_LEFT:    shifted = {alu[WIDE_W-2:0], shift_fill_i};
            SPC_SHIFT_RIGHT:   shifted = {shift_fill_i, alu[WIDE_W-1:1]};
            SPC_SHIFT_RIGHT_F: shifted = {alu[16], alu[WIDE_W-1:1]};
            default:           shifted = alu;
        endcase
        // 16-bit registers shift at bit 15; wide ones shift over all 20
        if (!sel_wide && uword_i.spc == SPC_SHIFT_RIGHT) begin
            shifted[15] = shift_fill_i;
        end
        if (!sel_wide && uword_i.spc == SPC_SHIFT_RIGHT_F) begin
            shifted[15] = alu[15];
        end
        swap   = 1'b0;
        wr_lo  = uword_i.regfile_load_bit;
        wr_ext = uword_i.regfile_load_bit && sel_wide;
        wr_val = st_q.bus;
        case (uword_i.spc)
            SPC_LOW_FIELD: begin
                wr_ext = 1'b0;
                wr_val = bus_in_i;
            end
            SPC_UPPER_NIBBLE: begin
                wr_lo  = 1'b0;
                wr_val = {bus_in_i[3:0], 16'h0000};
            end
            SPC_PORTA_TO_BUS, SPC_ALU_DIRECT: begin
                wr_val = alu;
            end
            SPC_BYTE_SWAP: begin
                swap   = 1'b1;
                wr_val = {bus_in_i[3:0], bus_in_i[7:0], bus_in_i[15:8]};
            end
            SPC_SHIFT_LEFT, SPC_SHIFT_RIGHT, SPC_SHIFT_RIGHT_F: begin
                wr_val = shifted;
            end
            default: begin
                wr_val = internal_bus_o;
            end
        endcase
        if (!swap && uword_i.spc == SPC_NONE) begin
            wr_val = internal_bus_o;
        end
    end

    // writes land at the clock edge ending the microcycle
    always_ff @(posedge sys_clk_i) begin
        if (wr_lo) begin
            rf_lo_q[rf_sel] <= wr_val[15:0];
        end
        if (wr_ext) begin
            rf_ext_q[rf_sel] <= wr_val[19:16];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus, temporaries, registers
    assign internal_bus_o = uword_i.bus_other_src ? bus_in_i : alu;

    always_comb begin
        st_d       = st_q;
        st_d.bus   = internal_bus_o;
        st_d.flags.c16 = c16;
        st_d.flags.c20 = c20;
        st_d.flags.v16 = (op_a[15] == bsub[15]) && (sum[15] != op_a[15]);
        st_d.flags.v20 = (op_a[19] == bsub[19]) && (sum[19] != op_a[19]);
        if (uword_i.load_g) begin
            st_d.g = internal_bus_o;
        end
        if (uword_i.shift_op_middle != SHIFT_OP_MIDDLE_NONE) begin
            // q extends the file-path shift to form 32-bit shifts
            st_d.q = shdec_o.is_right ? {alu[0], st_q.q[15:1]}
                                      : {st_q.q[14:0], shift_fill_i};
        end else if (uword_i.load_q) begin
            st_d.q = internal_bus_o[15:0];
        end
        if (uword_i.load_f) begin
            st_d.func = internal_bus_o[15:0];
        end
        st_d.rdata = 16'h0000;
        if (reg_wr_i && reg_addr_i == REG_FUNC) begin
            st_d.func = reg_wdata_i;
        end
        if (reg_rd_i) begin
            if (reg_addr_i == REG_FUNC) begin
                st_d.rdata = st_q.func;
            end else if (reg_addr_i == REG_KEY) begin
                st_d.rdata = rf_lo_q[RF_KEY_LOC] & ~KEY_FIXED_MASK;
            end else if (reg_addr_i == REG_FLAGS) begin
                st_d.rdata = {12'h000, st_q.flags};
            end else begin
                st_d.rdata = st_q.q;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_o = st_q.rdata;
    assign flags_o     = st_q.flags;
    assign alu_out_o   = alu;

    ////////////////////////////////////////////////////////////////////////
    // key register decode
    logic [15:0] key_raw;
    assign key_raw = rf_lo_q[RF_KEY_LOC];
    always_comb begin
        key_o.ring          = key_raw[KEY_RING_LSB +: 2];
        key_o.privileged    = key_o.ring[1];
        key_o.proc_id       = key_raw[KEY_ID_LSB +: 4];
        key_o.level         = key_raw[KEY_LEVEL_LSB +: 6];
        key_o.level_highest = key_o.level == LEVEL_HIGHEST;
        key_o.level_lowest  = key_o.level == LEVEL_LOWEST;
    end

    ////////////////////////////////////////////////////////////////////////
    // software shift decode from functional register
    logic [3:0] sh_code;
    logic [4:0] cnt_field;
    assign sh_code   = {st_q.func[7], st_q.func[6], st_q.func[5], st_q.func[4]};
    assign cnt_field = st_q.func[7] ? st_q.func[4:0] : {1'b0, st_q.func[3:0]};
    always_comb begin
        shdec_o.shift_type = sh_code;
        shdec_o.is_double  = sh_code[3] || sh_code[1:0] == 2'b11;
        shdec_o.is_right   = sh_code[3] ? sh_code[2] : sh_code[2];
        shdec_o.is_arith   = sh_code[3] ? sh_code[1] : sh_code[1:0] == 2'b10;
        shdec_o.is_closed  = !sh_code[3] && sh_code[0];
        shdec_o.over15     = sh_code[3] && sh_code[0];
        shdec_o.count_from_r1 = cnt_field == 5'h00;
        shdec_o.count      = (cnt_field == 5'h00) ? rf_lo_q[RF_DATA_R1][4:0] : cnt_field;
        shdec_o.odd_reg    = st_q.func[14:12];
        shdec_o.even_reg   = {st_q.func[14:13], 1'b0};
    end

endmodule

/* File: testbench/ards_datapath_chk.sv */
`timescale 1ns/10ps
module ards_datapath_chk
    import ards_pkg::*;
(
    input  wire logic                        sys_clk_i,
    input  wire logic                        rst_n_i,
    input  wire ards_pkg::ards_uword_s       uword_i,
    input  wire logic [ards_pkg::WIDE_W-1:0] bus_in_i,
    input  wire logic                        reg_rd_i,
    input  wire logic [15:0]                 reg_rdata_o,
    input  wire logic [ards_pkg::WIDE_W-1:0] internal_bus_o,
    input  wire logic [ards_pkg::WIDE_W-1:0] alu_out_o,
    input  wire ards_pkg::ards_shdec_s       shdec_o
);
    logic rd_a;

    // port a shows the addressed file location
    assign rd_a = uword_i.alu_op == ALU_PASS_A && !uword_i.a_zero && !uword_i.rf_addr_from_f;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////////////////////////////
    a_bus_default: assert property (
        !uword_i.bus_other_src |-> internal_bus_o == alu_out_o) else $error("bus not fed by alu");
    a_ones_out: assert property (
        uword_i.alu_op == ALU_ONES |-> alu_out_o == 20'hfffff) else $error("ones output wrong");
    a_porta_zero: assert property (
        uword_i.alu_op == ALU_PASS_A && uword_i.a_zero |-> alu_out_o == 20'h00000) else $error("a zero wrong");
    a_q16_sign: assert property (
        uword_i.alu_op == ALU_PASS_B && !uword_i.b_zero && uword_i.b_src == BSRC_Q16
        |-> alu_out_o[19:16] == {4{alu_out_o[15]}}) else $error("q field not sign extended");
    a_data_sign: assert property (
        rd_a && !uword_i.rf_addr[4] |-> alu_out_o[19:16] == {4{alu_out_o[15]}}) else $error("data reg not extended");
    a_rf_hold: assert property (
        (rd_a && !uword_i.regfile_load_bit) ##1 (rd_a && $stable(uword_i.rf_addr))
        |-> $stable(alu_out_o)) else $error("file changed without load");
    a_write_visible: assert property (
        rd_a && $past(uword_i.regfile_load_bit) && $past(uword_i.spc) == SPC_NONE
        && $past(uword_i.bus_other_src) && !$past(uword_i.rf_addr_from_f)
        && $past(uword_i.rf_addr) == uword_i.rf_addr && uword_i.rf_addr[4]
        |-> alu_out_o == $past(bus_in_i)) else $error("write not visible next cycle");
    a_shdec_right: assert property (
        shdec_o.is_right == shdec_o.shift_type[2]) else $error("shift direction wrong");
    a_shdec_dbl: assert property (
        shdec_o.is_double == (shdec_o.shift_type == 4'h3 || shdec_o.shift_type == 4'h7
        || shdec_o.shift_type[3])) else $error("double decode wrong");

    c_swap: cover property (uword_i.regfile_load_bit && uword_i.spc == SPC_BYTE_SWAP);
    c_fill: cover property (uword_i.regfile_load_bit && uword_i.spc == SPC_SHIFT_RIGHT_F);
    c_read: cover property (reg_rd_i ##1 reg_rdata_o != 16'h0000);
endmodule

bind ards_datapath ards_datapath_chk ards_datapath_chk_inst (
    .sys_clk_i      (sys_clk_i),
    .rst_n_i        (rst_n_i),
    .uword_i        (uword_i),
    .bus_in_i       (bus_in_i),
    .reg_rd_i       (reg_rd_i),
    .reg_rdata_o    (reg_rdata_o),
    .internal_bus_o (internal_bus_o),
    .alu_out_o      (alu_out_o),
    .shdec_o        (shdec_o)
);

/* File: testbench/test_ards_datapath.sv */
`timescale 1ns/10ps
module test_ards_datapath;
    import ards_pkg::*;

    logic         sys_clk_i;
    logic         rst_n_i;
    ards_uword_s  uword_i;
    logic [19:0]  bus_in_i;
    logic         shift_fill_i;
    logic         reg_wr_i;
    logic         reg_rd_i;
    logic [1:0]   reg_addr_i;
    logic [15:0]  reg_wdata_i;
    logic [15:0]  reg_rdata_o;
    logic [19:0]  internal_bus_o;
    logic [19:0]  alu_out_o;
    ards_flags_s  flags_o;
    ards_key_s    key_o;
    ards_shdec_s  shdec_o;
    int           err_total;
    int           num_checks;
    ards_uword_s  u;
    logic [3:0]   c;
    ards_alu_e    ops[14] = '{ALU_AND, ALU_OR, ALU_XOR, ALU_NOTB, ALU_NOTA, ALU_SUB, ALU_ADD_P1,
                              ALU_A_P1, ALU_A_M1, ALU_PASS_B, ALU_ZERO, ALU_ONES, ALU_ZSUB, ALU_ADD};
    logic [19:0]  oexp[14] = '{20'h00010, 20'h0fff3, 20'h0ffe3, 20'hfffec, 20'hf000f, 20'h0ffdd, 20'h10004,
                              20'h0fff1, 20'h0ffef, 20'h00013, 20'h00000, 20'hfffff, 20'hfffed, 20'h10003};
    ards_spc_e    spcs[6] = '{SPC_SHIFT_LEFT, SPC_SHIFT_RIGHT, SPC_SHIFT_RIGHT_F, SPC_ALU_DIRECT,
                              SPC_PORTA_TO_BUS, SPC_LOW_FIELD};
    ards_alu_e    sops[6] = '{ALU_PASS_A, ALU_PASS_A, ALU_PASS_A, ALU_ONES, ALU_ZERO, ALU_PASS_A};
    logic [19:0]  sexp[6] = '{20'h2468a, 20'h091a2, 20'h891a2, 20'hfffff, 20'h00000, 20'h1beef};
    ards_bsrc_e   bsrc[4] = '{BSRC_Q16, BSRC_Q8, BSRC_Q7, BSRC_G};
    logic [19:0]  bexp[4] = '{20'hf81a5, 20'hfffa5, 20'h00025, 20'h00000};

    ards_datapath ards_datapath_inst (
        .sys_clk_i      (sys_clk_i),
        .rst_n_i        (rst_n_i),
        .uword_i        (uword_i),
        .bus_in_i       (bus_in_i),
        .shift_fill_i   (shift_fill_i),
        .reg_wr_i       (reg_wr_i),
        .reg_rd_i       (reg_rd_i),
        .reg_addr_i     (reg_addr_i),
        .reg_wdata_i    (reg_wdata_i),
        .reg_rdata_o    (reg_rdata_o),
        .internal_bus_o (internal_bus_o),
        .alu_out_o      (alu_out_o),
        .flags_o        (flags_o),
        .key_o          (key_o),
        .shdec_o        (shdec_o)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    ////////////////////////////////////////////////////////////////
    function automatic ards_uword_s mk(input logic ld, input logic [4:0] a, input ards_spc_e s,
                                       input ards_alu_e op, input logic oth);
        mk = '0;
        mk.regfile_load_bit = ld;
        mk.rf_addr = a;
        mk.spc = s;
        mk.alu_op = op;
        mk.bus_other_src = oth;
        mk.b_zero = 1'b1;
    endfunction

    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input ards_uword_s w, input logic [19:0] b);
        @(posedge sys_clk_i);
        uword_i <= w;
        bus_in_i <= b;
    endtask

    task automatic rf_wr(input logic [4:0] a, input ards_spc_e s, input logic [19:0] v);
        cyc(mk(1'b1, a, s, ALU_ZERO, 1'b1), v);
    endtask

    // reads a location back through port a in the cycle after
    task automatic rf_chk(input logic [4:0] a, input logic [19:0] exp);
        cyc(mk(1'b0, a, SPC_NONE, ALU_PASS_A, 1'b0), 20'h00000);
        #1;
        chk("regfile", {4'h0, exp}, {4'h0, alu_out_o});
    endtask

    task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic reg_read(input logic [1:0] a, input logic [15:0] exp);
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk("rdata", {8'h00, exp}, {8'h00, reg_rdata_o});
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk_i);
        err_total++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        err_total = 0;
        num_checks = 0;
        rst_n_i = 1'b0;
        uword_i = mk(1'b0, 5'h00, SPC_NONE, ALU_AND, 1'b0);
        bus_in_i = 20'h00000;
        shift_fill_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 2'h0;
        reg_wdata_i = 16'h0000;
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);

        rf_wr(5'h01, SPC_NONE, 20'h08123);
        rf_chk(5'h01, 20'hf8123);
        cyc(mk(1'b0, 5'h01, SPC_BYTE_SWAP, ALU_PASS_A, 1'b1), 20'h05555);
        rf_chk(5'h01, 20'hf8123);
        rf_wr(5'h10, SPC_NONE, 20'h12345);
        rf_chk(5'h10, 20'h12345);
        rf_wr(5'h10, SPC_UPPER_NIBBLE, 20'h0000a);
        rf_chk(5'h10, 20'ha2345);
        rf_wr(5'h02, SPC_BYTE_SWAP, 20'h01234);
        rf_chk(5'h02, 20'h03412);
        rf_wr(5'h11, SPC_BYTE_SWAP, 20'h0abcd);
        rf_chk(5'h11, 20'hdcdab);
        for (int i = 0; i < 6; i++) begin
            rf_wr(5'h13, SPC_NONE, 20'h12345);
            if (spcs[i] == SPC_LOW_FIELD) begin
                rf_wr(5'h13, SPC_LOW_FIELD, 20'h0beef);
            end else begin
                cyc(mk(1'b1, 5'h13, spcs[i], sops[i], 1'b0), 20'h00000);
            end
            rf_chk(5'h13, sexp[i]);
        end
        $display("test regfile writes done");

        u = mk(1'b0, 5'h00, SPC_NONE, ALU_AND, 1'b1);
        u.load_g = 1'b1;
        cyc(u, 20'h00013);
        u.load_g = 1'b0;
        u.load_q = 1'b1;
        cyc(u, 20'h081a5);
        rf_wr(5'h12, SPC_NONE, 20'h0fff0);
        for (int i = 0; i < 14; i++) begin
            u = mk(1'b0, 5'h12, SPC_NONE, ops[i], 1'b0);
            u.b_zero = 1'b0;
            cyc(u, 20'h00000);
            #1;
            chk("alu", {4'h0, oexp[i]}, {4'h0, alu_out_o});
            chk("bus", {4'h0, oexp[i]}, {4'h0, internal_bus_o});
        end
        cyc(mk(1'b0, 5'h00, SPC_NONE, ALU_AND, 1'b0), 20'h00000);
        #1;
        chk("flags", 24'h000008, {20'h00000, flags_o});
        u = mk(1'b0, 5'h12, SPC_NONE, ALU_PASS_A, 1'b0);
        u.a_zero = 1'b1;
        cyc(u, 20'h00000);
        #1;
        chk("azero", 24'h000000, {4'h0, alu_out_o});
        for (int i = 0; i < 4; i++) begin
            u = mk(1'b0, 5'h00, SPC_NONE, ALU_PASS_B, 1'b0);
            u.b_zero = (i == 3);
            u.b_src = bsrc[i];
            cyc(u, 20'h00000);
            #1;
            chk("bport", {4'h0, bexp[i]}, {4'h0, alu_out_o});
        end
        reg_read(2'h3, 16'h81a5);
        $display("test alu done");

        rf_wr(5'h0e, SPC_NONE, 20'h041ff);
        rf_chk(5'h01, 20'hf8123);
        chk("key", {9'h000, 2'b10, 1'b1, 4'h7, 6'h3f, 2'b01}, {9'h000, key_o});
        reg_read(2'h1, 16'h41ff);
        reg_write(2'h1, 16'hffff);
        reg_read(2'h1, 16'h41ff);
        rf_wr(5'h0e, SPC_NONE, 20'h0b000);
        rf_chk(5'h01, 20'hf8123);
        chk("key", {9'h000, 2'b01, 1'b0, 4'h0, 6'h00, 2'b10}, {9'h000, key_o});
        reg_read(2'h1, 16'h2000);
        $display("test key done");

        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            reg_write(2'h0, {4'h3, 4'h0, c, 4'h5});
            #1;
            chk("shdec", {3'h0, c, (c == 4'h3 || c == 4'h7 || c[3]), c[2],
                (c == 4'h2 || c == 4'h6 || c == 4'ha || c == 4'hb || c >= 4'he), (!c[3] && c[0]), (c[3] && c[0]),
                (c[3] ? {c[0], 4'h5} : 5'h05), 1'b0, 3'h3, 3'h2}, {3'h0, shdec_o});
        end
        reg_read(2'h0, 16'h30f5);
        reg_write(2'h0, 16'h3000);
        #1;
        chk("from_r1", 24'h000001, {23'h000000, shdec_o.count_from_r1});
        chk("r1count", 24'h000003, {19'h00000, shdec_o.count});
        u = mk(1'b0, 5'h00, SPC_NONE, ALU_AND, 1'b0);
        u.shift_op_middle = SHIFT_OP_MIDDLE_MIDDLE;
        cyc(u, 20'h00000);
        shift_fill_i <= 1'b1;
        u.shift_op_middle = SHIFT_OP_MIDDLE_NONE;
        cyc(u, 20'h00000);
        reg_read(2'h3, 16'h034b);
        $display("test shift decode done");
        finish_test();
    end
endmodule
